// ### pkg/pad_cell_params.svh
`ifndef PAD_CELL_PARAMS_SVH
`define PAD_CELL_PARAMS_SVH
// ----------------------------------------------------------------
// Bus geometry and register word indices
// ----------------------------------------------------------------
`define PC_ADDR_W      6
`define PC_DATA_W      32
`define PC_IDX_LSB     2
`define PC_IDX_W       4
`define PC_IDX_CTRL    4'h0
`define PC_IDX_POL     4'h1
`define PC_IDX_ELEM0   4'h2
`define PC_IDX_STATUS  4'h8
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PC_CTRL_W      7
`define PC_CTRL_ASYNC  0
`define PC_CTRL_IDDR   1
`define PC_CTRL_ODDR   2
`define PC_CTRL_TDDR   3
`define PC_CTRL_FWD    4
`define PC_CTRL_FALL   5
`define PC_CTRL_DIFF   6
`define PC_CTRL_INIT   8
`define PC_CTRL_RST    7'h00
// ----------------------------------------------------------------
// Polarity and connection register fields
// ----------------------------------------------------------------
`define PC_POL_W       11
`define PC_INV_ICE     0
`define PC_INV_OCE     1
`define PC_INV_TCE     2
`define PC_INV_SR      3
`define PC_INV_REV     4
`define PC_INV_CLK0    5
`define PC_INV_CLK1    6
`define PC_CONN_ICE    8
`define PC_CONN_OCE    9
`define PC_CONN_TCE    10
`define PC_POL_RST     11'h000
// ----------------------------------------------------------------
// Storage elements and their configuration fields
// ----------------------------------------------------------------
`define PC_NUM_ELEM    6
`define PC_E_IN0       0
`define PC_E_IN1       1
`define PC_E_OUT0      2
`define PC_E_OUT1      3
`define PC_E_TRI0      4
`define PC_E_TRI1      5
`define PC_EC_W        6
`define PC_EC_LATCH    0
`define PC_EC_OPT_LSB  1
`define PC_EC_OPT_MSB  3
`define PC_EC_HIGH     4
`define PC_EC_INIT     5
`define PC_EC_RST      6'h00
// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define PC_ST_PADOUT   6
`define PC_ST_PADOEN   7
`define PC_ST_PADIN    8
`define PC_Q_RST       1'h0
`define PC_SEL_RST     1'h0
`define PC_WAIT_RST    1'h1
`define PC_RDATA_RST   32'h00000000
`endif

// ### pkg/pad_cell_pkg.sv
package pad_cell_pkg;
    typedef enum logic [2:0] {
        SR_NONE         = 3'h0,
        SR_SYNC_SET     = 3'h1,
        SR_SYNC_RESET   = 3'h2,
        SR_SYNC_BOTH    = 3'h3,
        SR_ASYNC_PRESET = 3'h4,
        SR_ASYNC_CLEAR  = 3'h5,
        SR_ASYNC_BOTH   = 3'h6
    } sr_option_type;
endpackage

// ### hw/storage_element.sv
`timescale 1ns/1ps
`include "pad_cell_params.svh"
module storage_element (
    // Clock and cell-wide controls
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        ce,
    input  wire logic                        asyncStyle,
    input  wire logic                        initPulse,
    // Element controls, polarity already applied
    input  wire logic                        phaseClk,
    input  wire logic                        pairEn,
    input  wire logic                        forceStateInput,
    input  wire logic                        oppositeForceInput,
    input  wire logic                        d,
    // Element configuration
    input  wire logic                        latchMode,
    input  wire pad_cell_pkg::sr_option_type forceOption,
    input  wire logic                        forceToOneSetting,
    input  wire logic                        initialOneSetting,
    // Stored value
    output logic                             q
);
    logic q_q, q_d, phasePrev_q, phasePrev_d;
    logic hasSet, hasReset, setReq, resetReq, clkEvent, forceEvent;

    always_comb begin
        hasSet = 1'b0;
        hasReset = 1'b0;
        unique case (forceOption)
            pad_cell_pkg::SR_NONE: ;
            pad_cell_pkg::SR_SYNC_SET,
            pad_cell_pkg::SR_ASYNC_PRESET: hasSet = 1'b1;
            pad_cell_pkg::SR_SYNC_RESET,
            pad_cell_pkg::SR_ASYNC_CLEAR: hasReset = 1'b1;
            pad_cell_pkg::SR_SYNC_BOTH,
            pad_cell_pkg::SR_ASYNC_BOTH: begin
                hasSet = 1'b1;
                hasReset = 1'b1;
            end
            default: ;
        endcase
        // The opposite input always drives the other level.
        setReq = hasSet && (forceToOneSetting ? forceStateInput
                                              : oppositeForceInput);
        resetReq = hasReset && (forceToOneSetting ? oppositeForceInput
                                                  : forceStateInput);
        clkEvent = latchMode ? phaseClk : (phaseClk && !phasePrev_q);
        // The cell style, not the option code, decides the timing.
        forceEvent = asyncStyle || clkEvent;
        phasePrev_d = phaseClk;
        if (initPulse) begin
            q_d = initialOneSetting;
        end else if (forceEvent && resetReq) begin
            q_d = 1'b0;
        end else if (forceEvent && setReq) begin
            q_d = 1'b1;
        end else if (clkEvent && pairEn) begin
            q_d = d;
        end else begin
            q_d = q_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_q <= `PC_Q_RST;
            phasePrev_q <= `PC_Q_RST;
        end else if (ce) begin
            q_q <= q_d;
            phasePrev_q <= phasePrev_d;
        end
    end

    assign q = q_q;

    reset_wins_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !initPulse && forceEvent && resetReq |=> !q_q)
        else $error("Reset did not override set.");
    set_force_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !initPulse && forceEvent && setReq && !resetReq |=> q_q)
        else $error("Set did not force a one.");
    init_load_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && initPulse |=> q_q == $past(initialOneSetting))
        else $error("Initial value not loaded.");
    hold_off_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !initPulse && !pairEn && !(setReq || resetReq)
        |=> $stable(q_q))
        else $error("Element changed with its enable low.");
    capture_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !initPulse && clkEvent && pairEn && !setReq && !resetReq
        |=> q_q == $past(d))
        else $error("Element missed its data.");
    latch_seen_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        ce && latchMode && phaseClk && pairEn ##1 ce && phaseClk);
endmodule // storage_element

// ### hw/ddr_select.sv
`timescale 1ns/1ps
`include "pad_cell_params.svh"
module ddr_select (
    // Clock and controls
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic ddrEn,
    input  wire logic phase,
    // Register pair
    input  wire logic firstQ,
    input  wire logic secondQ,
    // Selected value and its complement
    output logic      sel,
    output logic      selN
);
    logic sel_q, sel_d;

    always_comb begin
        // One value per phase gives two values per period.
        sel_d = (ddrEn && !phase) ? secondQ : firstQ;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_q <= `PC_SEL_RST;
        end else if (ce) begin
            sel_q <= sel_d;
        end
    end

    assign sel = sel_q;
    assign selN = !sel_q;

    ddr_pick_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && ddrEn |=> sel_q == $past(phase ? firstQ : secondQ))
        else $error("Wrong register selected for the phase.");
    sdr_pick_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !ddrEn |=> sel_q == $past(firstQ))
        else $error("Single rate path did not use the first register.");
endmodule // ddr_select

// ### hw/pad_cell_storage_ddr.sv
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pad_cell_params.svh"
module pad_cell_storage_ddr #(
    parameter int ADDR_W = `PC_ADDR_W,
    parameter int DATA_W = `PC_DATA_W
) (
    // Clock, reset and clock enable
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    // Avalon-MM register slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // Double rate phase clocks, sampled as levels
    input  wire logic              ddrClk0,
    input  wire logic              ddrClk1,
    // Control inputs from user logic
    input  wire logic              inputPairClockEnable,
    input  wire logic              outputPairClockEnable,
    input  wire logic              tristatePairClockEnable,
    input  wire logic              forceStateInput,
    input  wire logic              oppositeForceInput,
    // User data
    input  wire logic              outData0,
    input  wire logic              outData1,
    input  wire logic              triData0,
    input  wire logic              triData1,
    output logic                   inData0,
    output logic                   inData1,
    // Pad side
    input  wire logic              padIn,
    input  wire logic              padInComp,
    output logic                   padOut,
    output logic                   padOutComp,
    output logic                   padOeN
);
    localparam int NUM_ELEM = `PC_NUM_ELEM;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [`PC_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [`PC_POL_W-1:0]  pol_q, pol_d;
    logic [`PC_EC_W-1:0]   elem_q [NUM_ELEM];
    logic [`PC_EC_W-1:0]   elem_d [NUM_ELEM];
    logic                  initPulse_q, initPulse_d;
    logic                  waitReq_q, waitReq_d;
    logic [DATA_W-1:0]     readData_q, readData_d;
    logic [`PC_IDX_W-1:0]  idx;
    logic                  access, commit;

    // ----------------------------------------------------------------
    // Datapath signals
    // ----------------------------------------------------------------
    logic                phase0, phase1, padValue, outD0, outD1;
    logic                iceEff, oceEff, tceEff, srEff, revEff;
    logic [NUM_ELEM-1:0] dVec, phaseVec, enVec, qVec;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    assign idx = address[`PC_IDX_LSB +: `PC_IDX_W];
    // The answer costs one wait cycle so read data can be registered.
    assign access = (read || write) && waitReq_q;
    assign commit = write && !waitReq_q;

    always_comb begin
        ctrl_d = ctrl_q;
        pol_d = pol_q;
        elem_d = elem_q;
        initPulse_d = 1'b0;
        waitReq_d = !access;
        readData_d = readData_q;
        if (commit) begin
            if (idx == `PC_IDX_CTRL) begin
                ctrl_d = writedata[`PC_CTRL_W-1:0];
                initPulse_d = writedata[`PC_CTRL_INIT];
            end
            if (idx == `PC_IDX_POL) begin
                pol_d = writedata[`PC_POL_W-1:0];
            end
            for (int i = 0; i < NUM_ELEM; i++) begin
                if (idx == `PC_IDX_ELEM0 + `PC_IDX_W'(i)) begin
                    elem_d[i] = writedata[`PC_EC_W-1:0];
                end
            end
        end
        if (access && read) begin
            readData_d = '0;
            if (idx == `PC_IDX_CTRL) begin
                readData_d[`PC_CTRL_W-1:0] = ctrl_q;
            end
            if (idx == `PC_IDX_POL) begin
                readData_d[`PC_POL_W-1:0] = pol_q;
            end
            for (int i = 0; i < NUM_ELEM; i++) begin
                if (idx == `PC_IDX_ELEM0 + `PC_IDX_W'(i)) begin
                    readData_d[`PC_EC_W-1:0] = elem_q[i];
                end
            end
            if (idx == `PC_IDX_STATUS) begin
                readData_d[NUM_ELEM-1:0] = qVec;
                readData_d[`PC_ST_PADOUT] = padOut;
                readData_d[`PC_ST_PADOEN] = padOeN;
                readData_d[`PC_ST_PADIN] = padIn;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q <= `PC_CTRL_RST;
            pol_q <= `PC_POL_RST;
            for (int i = 0; i < NUM_ELEM; i++) begin
                elem_q[i] <= `PC_EC_RST;
            end
            initPulse_q <= 1'b0;
            waitReq_q <= `PC_WAIT_RST;
            readData_q <= `PC_RDATA_RST;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            pol_q <= pol_d;
            elem_q <= elem_d;
            initPulse_q <= initPulse_d;
            waitReq_q <= waitReq_d;
            readData_q <= readData_d;
        end
    end

    assign readdata = readData_q;
    assign waitrequest = waitReq_q;

    // ----------------------------------------------------------------
    // Control polarity, enables and data sources
    // ----------------------------------------------------------------
    always_comb begin
        // Both cells of a pair must see these same two phases.
        phase0 = ddrClk0 ^ pol_q[`PC_INV_CLK0] ^ ctrl_q[`PC_CTRL_FALL];
        // Opposite phases are taken as given by the clock source.
        phase1 = ddrClk1 ^ pol_q[`PC_INV_CLK1] ^ ctrl_q[`PC_CTRL_FALL];
        iceEff = pol_q[`PC_CONN_ICE] ?
                 inputPairClockEnable ^ pol_q[`PC_INV_ICE] : 1'b1;
        oceEff = pol_q[`PC_CONN_OCE] ?
                 outputPairClockEnable ^ pol_q[`PC_INV_OCE] : 1'b1;
        tceEff = pol_q[`PC_CONN_TCE] ?
                 tristatePairClockEnable ^ pol_q[`PC_INV_TCE] : 1'b1;
        srEff = forceStateInput ^ pol_q[`PC_INV_SR];
        revEff = oppositeForceInput ^ pol_q[`PC_INV_REV];
        // A crude receiver: a one only when the true leg leads.
        padValue = ctrl_q[`PC_CTRL_DIFF] ? (padIn && !padInComp)
                                        : padIn;
        // Forwarding loads one and zero so that, with PC_CTRL_ODDR set, the pad mirrors the clock.
        outD0 = ctrl_q[`PC_CTRL_FWD] ? 1'b1 : outData0;
        outD1 = ctrl_q[`PC_CTRL_FWD] ? 1'b0 : outData1;
        dVec = {triData1, triData0, outD1, outD0, padValue, padValue};
        phaseVec = {phase1, phase0, phase1, phase0, phase1, phase0};
        enVec = {tceEff, tceEff, oceEff, oceEff, iceEff, iceEff};
    end

    // ----------------------------------------------------------------
    // Storage elements
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_ELEM; i++) begin : gElem
        storage_element uElem (
            .clk                (clk),
            .reset_n            (reset_n),
            .ce                 (ce),
            .asyncStyle         (ctrl_q[`PC_CTRL_ASYNC]),
            .initPulse          (initPulse_q),
            .phaseClk           (phaseVec[i]),
            .pairEn             (enVec[i]),
            .forceStateInput    (srEff),
            .oppositeForceInput (revEff),
            .d                  (dVec[i]),
            .latchMode          (elem_q[i][`PC_EC_LATCH]),
            .forceOption        (pad_cell_pkg::sr_option_type'(
                                 elem_q[i][`PC_EC_OPT_MSB:`PC_EC_OPT_LSB])),
            .forceToOneSetting  (elem_q[i][`PC_EC_HIGH]),
            .initialOneSetting  (elem_q[i][`PC_EC_INIT]),
            .q                  (qVec[i])
        );
    end

    assign inData0 = qVec[`PC_E_IN0];
    assign inData1 = qVec[`PC_E_IN1];

    // ----------------------------------------------------------------
    // Double rate selection toward the pad
    // ----------------------------------------------------------------
    ddr_select uOutSel (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .ddrEn   (ctrl_q[`PC_CTRL_ODDR]),
        .phase   (phase0),
        .firstQ  (qVec[`PC_E_OUT0]),
        .secondQ (qVec[`PC_E_OUT1]),
        .sel     (padOut),
        .selN    (padOutComp)
    );

    // A high three-state value releases the pad, so it is the low-active
    // enable as it stands.
    ddr_select uTriSel (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .ddrEn   (ctrl_q[`PC_CTRL_TDDR]),
        .phase   (phase0),
        .firstQ  (qVec[`PC_E_TRI0]),
        .secondQ (qVec[`PC_E_TRI1]),
        .sel     (padOeN),
        .selN    ()
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    bus_answer_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && access |=> !waitReq_q)
        else $error("Bus request not answered in one cycle.");
    bus_release_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && !waitReq_q |=> waitReq_q)
        else $error("Waitrequest stayed low after the answer.");
    ctrl_write_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && commit && idx == `PC_IDX_CTRL
        |=> ctrl_q == $past(writedata[`PC_CTRL_W-1:0]))
        else $error("Control write did not take effect.");
    en_default_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !pol_q[`PC_CONN_OCE] |-> enVec[`PC_E_OUT0] && enVec[`PC_E_OUT1])
        else $error("Unconnected enable not asserted.");
    fwd_data_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ctrl_q[`PC_CTRL_FWD] |-> dVec[`PC_E_OUT0] && !dVec[`PC_E_OUT1])
        else $error("Forwarded clock data wrong.");
    // A low enable must hold the control and polarity settings, or a stall could lose a write.
    cfg_freeze_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !ce |=> $stable(ctrl_q) && $stable(pol_q))
        else $error("Settings changed with the clock enable low.");
    status_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ce && access && read && idx == `PC_IDX_STATUS
        |=> readData_q[NUM_ELEM-1:0] == $past(qVec))
        else $error("Status read did not show the element values.");
    write_seen_c: cover property (
        @(posedge clk) disable iff (!reset_n) ce && commit);
    read_seen_c: cover property (
        @(posedge clk) disable iff (!reset_n) ce && read && !waitReq_q);
    ddr_toggle_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        ctrl_q[`PC_CTRL_ODDR] && padOut ##1 !padOut ##1 padOut);
endmodule // pad_cell_storage_ddr

// ### test/pad_board_model.sv
`timescale 1ns/1ps
module pad_board_model (
    // Cell side of the pad
    input  wire logic padOut,
    input  wire logic padOeN,
    // Board side
    input  wire logic boardVal,
    output logic      padIn,
    output logic      padInComp
);
    // ----------------------------------------------------------------
    // Pad level
    // ----------------------------------------------------------------
    // The board lets go while the cell drives, so no contention is modelled.
    assign padIn     = padOeN ? boardVal : padOut;
    assign padInComp = ~padIn;
endmodule // pad_board_model

// ### test/pad_cell_storage_ddr_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, x, s) begin nTests++; if ((s) !== (x)) begin errCount++; \
    $display("[FAIL] %s expected %h seen %h", n, x, s); end end
module pad_cell_storage_ddr_tb_top;
    // ----------------------------------------------------------------
    // Signals and model state
    // ----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        ce = 1'b1;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        ddrClk0 = 1'b0;
    logic        ddrClk1 = 1'b1;
    logic [2:0]  pairEn = 3'h0;
    logic        forceIn = 1'b0;
    logic        oppIn = 1'b0;
    logic [3:0]  dat = 4'h0;
    logic        board = 1'b0;
    logic        bv = 1'b0;
    logic        padIn, padInComp, padOut, padOutComp, padOeN;
    logic        inData0, inData1;
    logic [5:0]  e = 6'h00;
    logic [6:0]  ctrl = 7'h00;
    logic [63:0] note;
    logic [63:0] noteQ [$];
    logic [5:0]  ra [6] = '{6'h00, 6'h04, 6'h08, 6'h1C, 6'h20, 6'h3C};
    logic [8:0]  ft [7] = '{9'h0B5, 9'h0E6, 9'h033, 9'h036, 9'h0C5,
                            9'h054, 9'h022};
    logic [5:0]  ic [6] = '{6'h20, 6'h00, 6'h00, 6'h20, 6'h20, 6'h00};
    int          errCount = 0;
    int          nTests = 0;

    always #50 clk = ~clk;

    pad_cell_storage_ddr dut (.clk(clk), .reset_n(reset_n), .ce(ce),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .ddrClk0(ddrClk0), .ddrClk1(ddrClk1),
        .inputPairClockEnable(pairEn[0]), .outputPairClockEnable(pairEn[1]),
        .tristatePairClockEnable(pairEn[2]), .forceStateInput(forceIn),
        .oppositeForceInput(oppIn), .outData0(dat[0]), .outData1(dat[1]),
        .triData0(dat[2]), .triData1(dat[3]), .inData0(inData0),
        .inData1(inData1), .padIn(padIn), .padInComp(padInComp),
        .padOut(padOut), .padOutComp(padOutComp), .padOeN(padOeN));

    pad_board_model pad (.padOut(padOut), .padOeN(padOeN), .boardVal(board),
        .padIn(padIn), .padInComp(padInComp));

    // ----------------------------------------------------------------
    // Bus, phase and bookkeeping tasks
    // ----------------------------------------------------------------
    task automatic finalReport;
        if (errCount == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= w;
        read      <= ~w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] x,
                      input logic [31:0] m);
        noteQ.push_back({m, x});
        bus(1'b0, a, 32'h0);
    endtask

    // The two phases always move together, so they stay in antiphase.
    task automatic ph(input logic p);
        ddrClk0 <= p;
        ddrClk1 <= ~p;
        repeat (3) @(posedge clk);
    endtask

    function automatic logic [31:0] stat(input logic hi);
        logic o, t;
        o = (ctrl[2] && !hi) ? e[3] : e[2];
        t = (ctrl[3] && !hi) ? e[5] : e[4];
        return {23'h0, t ? bv : o, t, o, e};
    endfunction

    task automatic cyc(input logic [2:0] en, input logic [3:0] d,
                       input logic b);
        logic [31:0] s;
        dat   <= d;
        board <= b;
        bv    = b;
        s     = stat(1'b0);
        ph(1'b1);
        if (en[0]) e[0] = s[8];
        if (en[1]) e[2] = ctrl[4] | d[0];
        if (en[2]) e[4] = d[2];
        rd(6'h20, stat(1'b1), 32'h1FF);
        s = stat(1'b1);
        ph(1'b0);
        if (en[0]) e[1] = s[8];
        if (en[1]) e[3] = ~ctrl[4] & d[1];
        if (en[2]) e[5] = d[3];
        rd(6'h20, stat(1'b0), 32'h1FF);
    endtask

    // ----------------------------------------------------------------
    // Result monitor and watchdog
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) begin
            note = noteQ.pop_front();
            `CHK("readdata", note[31:0], readdata & note[63:32])
            `CHK("padOutComp", ~padOut, padOutComp)
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        errCount++;
        finalReport();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(20421));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) rd(ra[i], 32'h0, 32'hFFFFFFFF);
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        rd(6'h3C, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, 6'h04, 32'h505);
        rd(6'h04, 32'h505, 32'hFFFFFFFF);
        bus(1'b1, 6'h1C, 32'h3F);
        rd(6'h1C, 32'h3F, 32'hFFFFFFFF);
        bus(1'b1, 6'h1C, 32'h0);
        bus(1'b1, 6'h04, 32'h0);
        // Enables left unconnected must still let the pairs load.
        repeat (10) begin
            ctrl = 7'($urandom) & 7'h5F;
            bus(1'b1, 6'h00, {25'h0, ctrl});
            cyc(3'h7, 4'($urandom), 1'($urandom));
        end
        ctrl = 7'h00;
        bus(1'b1, 6'h00, 32'h0);
        bus(1'b1, 6'h04, 32'h700);
        pairEn <= 3'h7;
        cyc(3'h7, 4'($urandom), 1'($urandom));
        pairEn <= 3'h0;
        cyc(3'h0, 4'hF, 1'b1);
        bus(1'b1, 6'h04, 32'h707);
        cyc(3'h7, 4'($urandom), 1'($urandom));
        bus(1'b1, 6'h04, 32'h0);
        ctrl = 7'h01;
        bus(1'b1, 6'h00, 32'h1);
        foreach (ft[i]) begin
            bus(1'b1, 6'h10, {26'h0, ft[i][8:3]});
            forceIn <= ft[i][2];
            oppIn   <= ft[i][1];
            repeat (3) @(posedge clk);
            rd(6'h20, 32'h4*ft[i][0], 32'h4);
            forceIn <= 1'b0;
            oppIn   <= 1'b0;
        end
        bus(1'b1, 6'h00, 32'h0);
        bus(1'b1, 6'h10, 32'h16);
        dat     <= 4'h0;
        forceIn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(6'h20, 32'h0, 32'h4);
        ph(1'b1);
        rd(6'h20, 32'h4, 32'h4);
        forceIn <= 1'b0;
        ph(1'b0);
        bus(1'b1, 6'h10, 32'h01);
        dat <= 4'h1;
        ph(1'b1);
        dat <= 4'h0;
        repeat (3) @(posedge clk);
        rd(6'h20, 32'h0, 32'h4);
        ph(1'b0);
        dat <= 4'h1;
        repeat (3) @(posedge clk);
        rd(6'h20, 32'h0, 32'h4);
        foreach (ic[i]) bus(1'b1, 6'(8 + 4 * i), {26'h0, ic[i]});
        bus(1'b1, 6'h00, 32'h100);
        repeat (3) @(posedge clk);
        rd(6'h20, 32'h19, 32'h3F);
        rd(6'h00, 32'h0, 32'hFFFFFFFF);
        finalReport();
    end
endmodule // pad_cell_storage_ddr_tb_top
